// ==== hw/irq_line_mapper.sv ====
// Purpose: Combines every interrupt source onto the legacy IRQ lines its code selects.
// Assumes: Sources are active-high levels on the system clock.
// Notes: Purely combinational; the caller registers the result.
`timescale 1ns/100ps
module irq_line_mapper (
  input wire logic [irq_steer_pkg::NUM_SRC-1:0] i_src,
  input wire logic [irq_steer_pkg::NUM_SRC*irq_steer_pkg::CODE_W-1:0] i_codes,
  output logic [irq_steer_pkg::IRQ_LINES-1:0] o_lines
);

  always_comb begin
    o_lines = '0;
    for (int i = 0; i < irq_steer_pkg::NUM_SRC; i++) begin
      // Shared lines are a wired OR of every requesting source mapped there.
      if (i_src[i]) begin
        o_lines = o_lines | irq_steer_pkg::steer_code_to_lines(
          i_codes[i*irq_steer_pkg::CODE_W +: irq_steer_pkg::CODE_W]);
      end
    end
  end

endmodule // irq_line_mapper

// ==== hw/irq_steer_pkg.sv ====
// Purpose: Shared constants for the interrupt steering and UART decode block.
// Assumes: Avalon-MM byte addresses, 32-bit data, one word per register.
// Notes: Steering codes map to legacy IRQ numbers through steer_code_to_lines.
package irq_steer_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned IRQ_LINES = 16;
  localparam int unsigned CODE_W = 4;
  localparam int unsigned NUM_SRC = 9;
  localparam int unsigned NUM_PCI = 4;
  localparam int unsigned UART_BASE_LSB = 3;
  localparam int unsigned UART_BASE_W = 29;

  localparam logic [7:0] OFS_UART_BASE = 8'h54;
  localparam logic [7:0] OFS_STEER = 8'h58;
  localparam logic [7:0] OFS_UART_CTRL = 8'h60;
  localparam logic [7:0] OFS_STATUS = 8'h64;

  localparam logic [31:0] RST_UART_BASE = 32'h000003F8;
  localparam logic [31:0] RST_STEER = 32'h00000000;
  localparam logic [7:0] RST_UART_CTRL = 8'h00;

  localparam int unsigned CTRL_EN_BIT = 7;
  localparam int unsigned STATUS_LINES_LSB = 16;

  // Source index order inside the source vector and the code vector.
  localparam int unsigned SRC_PCI_A = 0;
  localparam int unsigned SRC_PCI_B = 1;
  localparam int unsigned SRC_PCI_C = 2;
  localparam int unsigned SRC_PCI_D = 3;
  localparam int unsigned SRC_NET_A = 4;
  localparam int unsigned SRC_NET_B = 5;
  localparam int unsigned SRC_USB11 = 6;
  localparam int unsigned SRC_USB2 = 7;
  localparam int unsigned SRC_UART = 8;

  // Turns a 4-bit steering code into a one-hot IRQ line vector; zero when disabled or reserved.
  function automatic logic [15:0] steer_code_to_lines(input logic [3:0] code);
    logic [15:0] lines;
    lines = 16'h0000;
    unique case (code)
      4'h1: lines[9] = 1'b1;
      4'h2: lines[3] = 1'b1;
      4'h3: lines[10] = 1'b1;
      4'h4: lines[4] = 1'b1;
      4'h5: lines[5] = 1'b1;
      4'h6: lines[7] = 1'b1;
      4'h7: lines[6] = 1'b1;
      4'h8: lines[1] = 1'b1;
      4'h9: lines[11] = 1'b1;
      4'hB: lines[12] = 1'b1;
      4'hD: lines[14] = 1'b1;
      4'hF: lines[15] = 1'b1;
      default: lines = 16'h0000;
    endcase
    return lines;
  endfunction

endpackage

// ==== hw/irq_steering_top.sv ====
// Purpose: Interrupt steering table and internal UART I/O window decode.
// Assumes: Avalon-MM slave with waitrequest on a 10 MHz clock.
// Notes: Every access takes exactly one wait state.
`timescale 1ns/100ps

// Functional notes
// (R1) UART base address bits 31..3 are held writable in register bits 31..3.
// (R2) UART base bits 2..0 read zero; writes to them change nothing.
// (R3) With decoding on, I/O addresses matching base bits 31..3 are claimed.
// (R4) Control bit 7 enables UART decoding; zero disables it.
// (R5) Steering register: eight 4-bit fields; 31..28 USB2 host, 27..24 USB1.1 host.
// (R6) Code 0000 disables routing; the source drives no IRQ line.
// (R7) Codes 1..7 select IRQ9, IRQ3, IRQ10, IRQ4, IRQ5, IRQ7, IRQ6.
// (R8) Bits 23..20 steer network controller B; codes 8-F per table, A/C/E reserved.
// (R9) Bits 19..16 steer network controller A with the shared encoding.
// (R10) Bits 15..12 steer PCI pin D with the shared encoding.
// (R11) Bits 11..8 steer PCI pin C with the shared encoding.
// (R12) Bits 7..4 steer PCI pin B, bits 3..0 steer PCI pin A.
// (R13) Software avoids reserved codes; shared lines assert while any mapped source requests.
module irq_steering_top (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [irq_steer_pkg::ADDR_W-1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [3:0] i_byteenable,
  input wire logic [irq_steer_pkg::DATA_W-1:0] i_writedata,
  output logic [irq_steer_pkg::DATA_W-1:0] o_readdata,
  output logic o_waitrequest,
  input wire logic i_usb2_irq,
  input wire logic i_usb11_irq,
  input wire logic i_net_a_irq,
  input wire logic i_net_b_irq,
  input wire logic i_uart_irq,
  input wire logic [irq_steer_pkg::NUM_PCI-1:0] i_pci_int_n,
  input wire logic [31:0] i_io_addr,
  input wire logic i_io_valid,
  output logic o_uart_sel,
  output logic [irq_steer_pkg::IRQ_LINES-1:0] o_irq
);

  typedef struct packed {
    logic waitrequest;
    logic [irq_steer_pkg::DATA_W-1:0] readdata;
    logic [irq_steer_pkg::UART_BASE_W-1:0] uart_base_addr_field;
    logic uart_decode_enable;
    logic [irq_steer_pkg::CODE_W-1:0] uart_irq_steer;
    logic [irq_steer_pkg::CODE_W-1:0] usb2_host_irq_steer;
    logic [irq_steer_pkg::CODE_W-1:0] usb11_host_irq_steer;
    logic [irq_steer_pkg::CODE_W-1:0] net_ctrl_b_irq_steer;
    logic [irq_steer_pkg::CODE_W-1:0] net_ctrl_a_irq_steer;
    logic [irq_steer_pkg::CODE_W-1:0] pci_pin_d_steer;
    logic [irq_steer_pkg::CODE_W-1:0] pci_pin_c_steer;
    logic [irq_steer_pkg::CODE_W-1:0] pci_pin_b_steer;
    logic [irq_steer_pkg::CODE_W-1:0] pci_pin_a_steer;
    logic uart_sel;
    logic [irq_steer_pkg::IRQ_LINES-1:0] irq;
  } top_state_s;

  top_state_s state_q;
  top_state_s state_d;

  logic [irq_steer_pkg::NUM_PCI-1:0] pci_int_sync_n;
  logic [irq_steer_pkg::NUM_SRC-1:0] src_active;
  logic [irq_steer_pkg::NUM_SRC*irq_steer_pkg::CODE_W-1:0] src_codes;
  logic [irq_steer_pkg::IRQ_LINES-1:0] mapped_lines;
  logic [31:0] uart_base_word;
  logic [31:0] steer_word;
  logic [31:0] ctrl_word;
  logic [31:0] status_word;
  logic [31:0] uart_base_new;
  logic [31:0] steer_new;
  logic [31:0] ctrl_new;
  logic bus_req;
  logic bus_done;

  // Byte-lane merge shared by every writable register.
  function automatic logic [31:0] merge_lanes(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0] lanes
  );
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (lanes[b]) begin
        res[b*8 +: 8] = new_val[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // PCI interrupt pins arrive from outside the clock domain.
  pin_sync2 u_pci_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_pin(i_pci_int_n),
    .o_sync(pci_int_sync_n)
  );

  // Source vector in the package's index order.
  always_comb begin
    src_active = '0;
    src_active[irq_steer_pkg::SRC_PCI_A] = ~pci_int_sync_n[0];
    src_active[irq_steer_pkg::SRC_PCI_B] = ~pci_int_sync_n[1];
    src_active[irq_steer_pkg::SRC_PCI_C] = ~pci_int_sync_n[2];
    src_active[irq_steer_pkg::SRC_PCI_D] = ~pci_int_sync_n[3];
    src_active[irq_steer_pkg::SRC_NET_A] = i_net_a_irq;
    src_active[irq_steer_pkg::SRC_NET_B] = i_net_b_irq;
    src_active[irq_steer_pkg::SRC_USB11] = i_usb11_irq;
    src_active[irq_steer_pkg::SRC_USB2] = i_usb2_irq;
    src_active[irq_steer_pkg::SRC_UART] = i_uart_irq;
  end

  // Each source except the UART takes the code from its own field of the steering register; the UART uses control bits 3..0.
  always_comb begin
    src_codes = '0;
    src_codes[irq_steer_pkg::SRC_PCI_A*irq_steer_pkg::CODE_W +: irq_steer_pkg::CODE_W] =
      state_q.pci_pin_a_steer; // [R12]
    src_codes[irq_steer_pkg::SRC_PCI_B*irq_steer_pkg::CODE_W +: irq_steer_pkg::CODE_W] =
      state_q.pci_pin_b_steer; // [R12]
    src_codes[irq_steer_pkg::SRC_PCI_C*irq_steer_pkg::CODE_W +: irq_steer_pkg::CODE_W] =
      state_q.pci_pin_c_steer; // [R11]
    src_codes[irq_steer_pkg::SRC_PCI_D*irq_steer_pkg::CODE_W +: irq_steer_pkg::CODE_W] =
      state_q.pci_pin_d_steer; // [R10]
    src_codes[irq_steer_pkg::SRC_NET_A*irq_steer_pkg::CODE_W +: irq_steer_pkg::CODE_W] =
      state_q.net_ctrl_a_irq_steer; // [R9]
    src_codes[irq_steer_pkg::SRC_NET_B*irq_steer_pkg::CODE_W +: irq_steer_pkg::CODE_W] =
      state_q.net_ctrl_b_irq_steer; // [R8]
    src_codes[irq_steer_pkg::SRC_USB11*irq_steer_pkg::CODE_W +: irq_steer_pkg::CODE_W] =
      state_q.usb11_host_irq_steer; // [R5]
    src_codes[irq_steer_pkg::SRC_USB2*irq_steer_pkg::CODE_W +: irq_steer_pkg::CODE_W] =
      state_q.usb2_host_irq_steer; // [R5]
    src_codes[irq_steer_pkg::SRC_UART*irq_steer_pkg::CODE_W +: irq_steer_pkg::CODE_W] =
      state_q.uart_irq_steer;
  end

  // Disabled and reserved codes decode to no line; shared lines are ORed. [R6] [R7] [R8] [R13]
  irq_line_mapper u_mapper (
    .i_src(src_active),
    .i_codes(src_codes),
    .o_lines(mapped_lines)
  );

  // Register images as software sees them.
  always_comb begin
    uart_base_word = {state_q.uart_base_addr_field, 3'b000}; // [R2]
    steer_word = {state_q.usb2_host_irq_steer,
                  state_q.usb11_host_irq_steer,
                  state_q.net_ctrl_b_irq_steer,
                  state_q.net_ctrl_a_irq_steer,
                  state_q.pci_pin_d_steer,
                  state_q.pci_pin_c_steer,
                  state_q.pci_pin_b_steer,
                  state_q.pci_pin_a_steer}; // [R5]
    ctrl_word = '0;
    ctrl_word[irq_steer_pkg::CTRL_EN_BIT] = state_q.uart_decode_enable; // [R4]
    ctrl_word[irq_steer_pkg::CODE_W-1:0] = state_q.uart_irq_steer;
    status_word = '0;
    status_word[irq_steer_pkg::STATUS_LINES_LSB +: irq_steer_pkg::IRQ_LINES] = state_q.irq;
    status_word[irq_steer_pkg::NUM_SRC-1:0] = src_active;
  end

  // Values after a byte-enabled write, ahead of field extraction.
  always_comb begin
    uart_base_new = merge_lanes(uart_base_word, i_writedata, i_byteenable);
    steer_new = merge_lanes(steer_word, i_writedata, i_byteenable);
    ctrl_new = merge_lanes(ctrl_word, i_writedata, i_byteenable);
  end

  // A request is accepted on the first edge it is seen and completes on the next.
  assign bus_req = i_read | i_write;
  assign bus_done = bus_req & ~state_q.waitrequest;

  always_comb begin
    state_d = state_q;
    state_d.waitrequest = 1'b1;

    if (bus_req && state_q.waitrequest) begin
      // Read data is prepared during the wait state so it stands when waitrequest drops.
      state_d.waitrequest = 1'b0;
      if (i_read) begin
        unique case (i_address)
          irq_steer_pkg::OFS_UART_BASE: state_d.readdata = uart_base_word;
          irq_steer_pkg::OFS_STEER: state_d.readdata = steer_word;
          irq_steer_pkg::OFS_UART_CTRL: state_d.readdata = ctrl_word;
          irq_steer_pkg::OFS_STATUS: state_d.readdata = status_word;
          default: state_d.readdata = '0;
        endcase
      end
    end

    // Writes land only at the completing edge; unmapped and read-only targets ignore them.
    if (bus_done && i_write) begin
      unique case (i_address)
        irq_steer_pkg::OFS_UART_BASE: begin
          state_d.uart_base_addr_field =
            uart_base_new[31:irq_steer_pkg::UART_BASE_LSB]; // [R1] [R2]
        end
        irq_steer_pkg::OFS_STEER: begin
          {state_d.usb2_host_irq_steer,
           state_d.usb11_host_irq_steer,
           state_d.net_ctrl_b_irq_steer,
           state_d.net_ctrl_a_irq_steer,
           state_d.pci_pin_d_steer,
           state_d.pci_pin_c_steer,
           state_d.pci_pin_b_steer,
           state_d.pci_pin_a_steer} = steer_new; // [R5] [R8] [R9] [R10] [R11] [R12]
        end
        irq_steer_pkg::OFS_UART_CTRL: begin
          state_d.uart_decode_enable = ctrl_new[irq_steer_pkg::CTRL_EN_BIT]; // [R4]
          state_d.uart_irq_steer = ctrl_new[irq_steer_pkg::CODE_W-1:0];
        end
        default: begin
          state_d.uart_decode_enable = state_q.uart_decode_enable;
        end
      endcase
    end

    // The UART owns an eight-byte window; the low three address bits are ignored.
    state_d.uart_sel = state_q.uart_decode_enable & i_io_valid &
      (i_io_addr[31:irq_steer_pkg::UART_BASE_LSB] == state_q.uart_base_addr_field); // [R3] [R4]

    state_d.irq = mapped_lines; // [R13]
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q.waitrequest <= 1'b1;
      state_q.readdata <= '0;
      state_q.uart_base_addr_field <=
        irq_steer_pkg::RST_UART_BASE[31:irq_steer_pkg::UART_BASE_LSB];
      state_q.uart_decode_enable <= irq_steer_pkg::RST_UART_CTRL[irq_steer_pkg::CTRL_EN_BIT];
      state_q.uart_irq_steer <= irq_steer_pkg::RST_UART_CTRL[irq_steer_pkg::CODE_W-1:0];
      {state_q.usb2_host_irq_steer,
       state_q.usb11_host_irq_steer,
       state_q.net_ctrl_b_irq_steer,
       state_q.net_ctrl_a_irq_steer,
       state_q.pci_pin_d_steer,
       state_q.pci_pin_c_steer,
       state_q.pci_pin_b_steer,
       state_q.pci_pin_a_steer} <= irq_steer_pkg::RST_STEER;
      state_q.uart_sel <= 1'b0;
      state_q.irq <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_waitrequest = state_q.waitrequest;
  assign o_readdata = state_q.readdata;
  assign o_uart_sel = state_q.uart_sel;
  assign o_irq = state_q.irq;

endmodule // irq_steering_top

// ==== hw/pin_sync2.sv ====
// Purpose: Two-stage synchroniser for the PCI interrupt pins.
// Assumes: Pins are asynchronous, active low, idle high.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/100ps
module pin_sync2 (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [irq_steer_pkg::NUM_PCI-1:0] i_pin,
  output logic [irq_steer_pkg::NUM_PCI-1:0] o_sync
);

  typedef struct packed {
    logic [irq_steer_pkg::NUM_PCI-1:0] meta;
    logic [irq_steer_pkg::NUM_PCI-1:0] stable;
  } sync_s;

  sync_s state_q;
  sync_s state_d;

  always_comb begin
    state_d = state_q;
    state_d.meta = i_pin;
    state_d.stable = state_q.meta;
  end

  // Reset to the idle level so no spurious request appears after reset.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= '1;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_sync = state_q.stable;

endmodule // pin_sync2

// ==== testbench/irq_steering_properties.sv ====
// Purpose: Port-level properties of the steering and UART decode block.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Sees only the top ports, so register contents are judged indirectly.
`timescale 1ns/100ps
module irq_steering_checker (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [irq_steer_pkg::ADDR_W-1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [irq_steer_pkg::DATA_W-1:0] o_readdata,
  input wire logic o_waitrequest,
  input wire logic i_usb2_irq,
  input wire logic i_usb11_irq,
  input wire logic i_net_a_irq,
  input wire logic i_net_b_irq,
  input wire logic i_uart_irq,
  input wire logic [irq_steer_pkg::NUM_PCI-1:0] i_pci_int_n,
  input wire logic [31:0] i_io_addr,
  input wire logic i_io_valid,
  input wire logic o_uart_sel,
  input wire logic [irq_steer_pkg::IRQ_LINES-1:0] o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic quiet;
  assign quiet = !(i_usb2_irq | i_usb11_irq | i_net_a_irq | i_net_b_irq | i_uart_irq) && (&i_pci_int_n);
  sequence read_done(a);
    i_read && !o_waitrequest && (i_address == a);
  endsequence
  sequence same_window;
    i_io_valid && $past(i_io_valid) && $past(i_rst_n) && !i_write && !$past(i_write)
      && (i_io_addr[31:3] == $past(i_io_addr[31:3]));
  endsequence
  chk_wait_one: assert property ($fell(o_waitrequest) |=> o_waitrequest)
    else $error("waitrequest stayed low for more than one cycle");
  chk_answer_next: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
    else $error("request not answered after one wait cycle");
  chk_base_low_zero: assert property (read_done(8'h54) |-> o_readdata[2:0] == 3'h0)
    else $error("base register low bits not zero");
  chk_ctrl_rsvd_zero: assert property (read_done(8'h60) |-> o_readdata[6:4] == 3'h0)
    else $error("control reserved bits not zero");
  chk_unmapped_zero: assert property (i_read && !o_waitrequest
    && !(i_address inside {8'h54, 8'h58, 8'h60, 8'h64}) |-> o_readdata == 32'h00000000)
    else $error("unmapped read not zero");
  chk_no_stray_line: assert property (!(o_irq[0] || o_irq[2] || o_irq[8] || o_irq[13]))
    else $error("a line no code can select is active");
  chk_quiet_no_irq: assert property (quiet [*5] |-> o_irq == 16'h0000)
    else $error("line active with no source requesting");
  chk_sel_needs_valid: assert property (o_uart_sel |-> $past(i_io_valid))
    else $error("uart select without an io cycle");
  chk_sel_low_bits: assert property (same_window |=> o_uart_sel == $past(o_uart_sel))
    else $error("uart select depends on address bits 2..0");
endmodule // irq_steering_checker

bind irq_steering_top irq_steering_checker u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_address(i_address),
  .i_read(i_read), .i_write(i_write), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
  .i_usb2_irq(i_usb2_irq), .i_usb11_irq(i_usb11_irq), .i_net_a_irq(i_net_a_irq), .i_net_b_irq(i_net_b_irq),
  .i_uart_irq(i_uart_irq), .i_pci_int_n(i_pci_int_n), .i_io_addr(i_io_addr), .i_io_valid(i_io_valid),
  .o_uart_sel(o_uart_sel), .o_irq(o_irq));

// ==== testbench/legacy_pic_model.sv ====
// Purpose: Behavioural legacy interrupt controller on the steered lines.
// Assumes: Lines are active-high levels on the system clock.
// Notes: Latches every line seen high until acknowledged.
`timescale 1ns/100ps
module legacy_pic_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [15:0] i_irq,
  input wire logic i_ack,
  output logic [15:0] o_pending
);
  // A line still high after an acknowledge latches again, since shared sources may still request.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pending <= 16'h0000;
    end else begin
      o_pending <= (o_pending & ~{16{i_ack}}) | i_irq;
    end
  end
endmodule // legacy_pic_model

// ==== testbench/tb_irq_steering_and_uart_decode.sv ====
// Purpose: Register, steering and decode tests for the steering block.
// Assumes: Avalon-MM master holding each request until waitrequest is seen low.
// Notes: The bus master samples waitrequest at the rising edge; only the watchdog ends a wait.
`timescale 1ns/100ps
module tb_irq_steering_and_uart_decode;
  logic i_clk, i_rst_n, i_read, i_write, i_io_valid, o_waitrequest, o_uart_sel, ack;
  logic i_usb2_irq, i_usb11_irq, i_net_a_irq, i_net_b_irq, i_uart_irq;
  logic [7:0] i_address;
  logic [3:0] i_byteenable, i_pci_int_n;
  logic [31:0] i_writedata, o_readdata, i_io_addr, q, v;
  logic [15:0] o_irq, pending;
  int err_total = 0;
  int checked = 0;

  irq_steering_top dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_byteenable(i_byteenable), .i_writedata(i_writedata), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .i_usb2_irq(i_usb2_irq), .i_usb11_irq(i_usb11_irq),
    .i_net_a_irq(i_net_a_irq), .i_net_b_irq(i_net_b_irq), .i_uart_irq(i_uart_irq), .i_pci_int_n(i_pci_int_n),
    .i_io_addr(i_io_addr), .i_io_valid(i_io_valid), .o_uart_sel(o_uart_sel), .o_irq(o_irq));
  legacy_pic_model pic (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_irq(o_irq), .i_ack(ack), .o_pending(pending));

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge i_clk);
    i_address <= a;
    i_writedata <= d;
    i_byteenable <= be;
    i_write <= wr;
    i_read <= !wr;
    // Read just after the edge, before the slave's own update, so this is what the edge saw.
    do begin
      @(posedge i_clk);
    end while (o_waitrequest !== 1'b0);
    q = o_readdata;
    i_write <= 1'b0;
    i_read <= 1'b0;
  endtask

  // Bit order follows the field order of the steering word, plus the UART source on top.
  task automatic set_src(input logic [8:0] act);
    @(posedge i_clk);
    i_pci_int_n <= ~act[3:0];
    i_net_a_irq <= act[4];
    i_net_b_irq <= act[5];
    i_usb11_irq <= act[6];
    i_usb2_irq <= act[7];
    i_uart_irq <= act[8];
    repeat (4) @(posedge i_clk);
    @(negedge i_clk);
  endtask

  task automatic io(input logic [31:0] a, input logic exp);
    @(posedge i_clk);
    i_io_addr <= a;
    i_io_valid <= 1'b1;
    @(posedge i_clk);
    @(negedge i_clk);
    chk({31'h0, o_uart_sel}, {31'h0, exp}, "uart select");
  endtask

  function automatic logic [15:0] lines_of(input logic [3:0] c);
    int tbl[16];
    tbl = '{-1, 9, 3, 10, 4, 5, 7, 6, 1, 11, -1, 12, -1, 14, -1, 15};
    return (tbl[c] < 0) ? 16'h0000 : (16'h0001 << tbl[c]);
  endfunction

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  initial begin
    #1000000;
    err_total++;
    stop_test;
  end

  initial begin
    {i_rst_n, i_read, i_write, i_io_valid, ack, i_address, i_byteenable, i_writedata, i_io_addr} = '0;
    {i_usb2_irq, i_usb11_irq, i_net_a_irq, i_net_b_irq, i_uart_irq} = '0;
    i_pci_int_n = 4'hF;
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (6) @(negedge i_clk);
    chk(32'(o_irq), 32'h00000000, "irq after reset");
    bus(1'b0, 8'h54, 32'h0, 4'hF); chk(q, 32'h000003F8, "base reset");
    bus(1'b0, 8'h58, 32'h0, 4'hF); chk(q, 32'h00000000, "steer reset");
    bus(1'b0, 8'h60, 32'h0, 4'hF); chk(q, 32'h00000000, "ctrl reset");
    bus(1'b1, 8'h54, 32'hFFFFFFFF, 4'hF);
    bus(1'b0, 8'h54, 32'h0, 4'hF); chk(q, 32'hFFFFFFF8, "base all ones");
    bus(1'b1, 8'h54, 32'h00000039, 4'h1);
    bus(1'b0, 8'h54, 32'h0, 4'hF); chk(q, 32'hFFFFFF38, "base lane 0");
    bus(1'b1, 8'h54, 32'h00001238, 4'hF);
    bus(1'b0, 8'h70, 32'h0, 4'hF); chk(q, 32'h00000000, "unmapped read");
    for (int f = 0; f < 8; f++) begin
      for (int c = 0; c < 16; c++) begin
        // Software keeps off the reserved codes.
        if (c == 10 || c == 12 || c == 14) continue;
        v = {28'h0000000, 4'(c)} << (4 * f);
        bus(1'b1, 8'h58, v, 4'hF);
        bus(1'b0, 8'h58, 32'h0, 4'hF); chk(q, v, "steer readback");
        set_src(9'h0FF); chk(32'(o_irq), 32'(lines_of(4'(c))), "steered line");
        set_src(9'h0FF & ~(9'h001 << f)); chk(32'(o_irq), 32'h0, "foreign source");
      end
    end
    bus(1'b1, 8'h58, 32'h00001001, 4'hF);
    set_src(9'h001); chk(32'(o_irq), 32'h00000200, "shared line pin a");
    set_src(9'h009); chk(32'(o_irq), 32'h00000200, "shared line both");
    bus(1'b0, 8'h64, 32'h0, 4'hF); chk(q, 32'h02000009, "status image");
    @(posedge i_clk);
    ack <= 1'b1;
    @(posedge i_clk);
    ack <= 1'b0;
    @(negedge i_clk);
    chk(32'(pending), 32'h00000200, "controller pending");
    set_src(9'h000);
    bus(1'b1, 8'h60, 32'h000000FF, 4'h1);
    bus(1'b0, 8'h60, 32'h0, 4'hF); chk(q, 32'h0000008F, "ctrl readback");
    set_src(9'h100); chk(32'(o_irq), 32'h00008000, "uart source");
    set_src(9'h000);
    io(32'h0000123F, 1'b1);
    io(32'h00001239, 1'b1);
    io(32'h00001240, 1'b0);
    io(32'h00001230, 1'b0);
    bus(1'b1, 8'h60, 32'h00000000, 4'h1);
    io(32'h00001238, 1'b0);
    stop_test;
  end
endmodule // tb_irq_steering_and_uart_decode
